/* File: asq_pkg.sv */
// Register map, field layout and event bits of the slot, window and result queue block
`default_nettype none
package asq_pkg;
	localparam int ADDR_W = 10;
	localparam logic [ADDR_W-1:0] OFS_SLOT6 = 10'h024;
	localparam logic [ADDR_W-1:0] OFS_SLOT7 = 10'h028;
	localparam logic [ADDR_W-1:0] OFS_UPPER = 10'h02C;
	localparam logic [ADDR_W-1:0] OFS_LOWER = 10'h030;
	localparam logic [ADDR_W-1:0] OFS_FIFO = 10'h038;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 10'h200;
	localparam logic [ADDR_W-1:0] OFS_INTSTAT = 10'h204;
	localparam logic [ADDR_W-1:0] OFS_INTCLR = 10'h208;
	localparam logic [ADDR_W-1:0] OFS_INTSET = 10'h20C;
	localparam logic [31:0] RST_VAL = 32'h0000_0000;
	// Slot configuration fields
	localparam int AVG_LSB = 24;
	localparam int AVG_W = 3;
	localparam int RES_LSB = 16;
	localparam int RES_W = 2;
	localparam int SEL_LSB = 8;
	localparam int SEL_W = 4;
	localparam int BIT_WIN = 1;
	localparam int BIT_ACTIVE = 0;
	localparam logic [31:0] CFG_WMASK = 32'h0703_0F03;
	// Input select codes
	localparam logic [SEL_W-1:0] CH_DIFF0 = 4'hA;
	localparam logic [SEL_W-1:0] CH_TEMP = 4'hC;
	localparam logic [SEL_W-1:0] CH_GND = 4'hE;
	// Limits and queue word
	localparam int LIM_W = 20;
	localparam int DATA_W = 20;
	localparam int SLOT_W = 3;
	localparam int SLOT_LSB = 28;
	localparam int CNT_LSB = 20;
	localparam int CNT_W = 8;
	localparam int SAMPLE_W = 14;
	localparam int FRAC_W = 6;
	localparam int ACC_W = 21;
	localparam logic [SLOT_W-1:0] SLOT_BASE = 3'h6;
	// Interrupt event bits
	localparam int INT_W = 6;
	localparam int EV_SAMPLE = 0;
	localparam int EV_SWEEP = 1;
	localparam int EV_Q75 = 2;
	localparam int EV_FULL = 3;
	localparam int EV_EXIT = 4;
	localparam int EV_ENTRY = 5;
endpackage : asq_pkg
`default_nettype wire

/* File: asq_slot_window_fifo.sv */
// Slot 6/7 configuration, window comparator, result queue and interrupt registers
`default_nettype none
module asq_slot_window_fifo
	import asq_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic i_sys_clk, // System clock
	input wire logic i_rst, // Async reset, high
	input wire logic [ADDR_W-1:0] i_addr, // Register byte address
	input wire logic [31:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [31:0] o_rdata, // Read data, cycle after strobe
	input wire logic i_meas_valid, // One raw measurement
	input wire logic [SLOT_W-1:0] i_meas_slot, // Slot of measurement
	input wire logic [SAMPLE_W-1:0] i_meas_data, // Raw 14-bit sample
	input wire logic i_scan_done, // Scan finished pulse
	output logic [1:0] o_slot_active, // Bit 0 slot 6, bit 1 slot 7
	output logic [1:0] o_slot_window_enable, // Window enable per slot
	output logic [AVG_W-1:0] o_slot6_average_count, // Averaging code
	output logic [AVG_W-1:0] o_slot7_average_count, // Averaging code
	output logic [RES_W-1:0] o_slot6_resolution, // Precision code
	output logic [RES_W-1:0] o_slot7_resolution, // Precision code
	output logic [SEL_W-1:0] o_slot6_input_select, // Input code
	output logic [SEL_W-1:0] o_slot7_input_select, // Input code
	output logic [1:0] o_slot_differential, // Pad pair selected
	output logic [1:0] o_slot_internal, // Internal source selected
	output logic o_irq // Level interrupt
);
	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam logic [CNT_W-1:0] Q_FULL = CNT_W'(FIFO_DEPTH);
	localparam logic [CNT_W-1:0] Q_75 = CNT_W'((FIFO_DEPTH * 3) / 4);

	logic [31:0] cfg_ff [2];
	logic [LIM_W-1:0] upper_ff;
	logic [LIM_W-1:0] lower_ff;
	logic [INT_W-1:0] irq_enable_ff;
	logic [INT_W-1:0] stat_ff;
	logic [31:0] rdata_ff;
	logic [SLOT_W+DATA_W-1:0] mem [FIFO_DEPTH];
	logic [PTR_W-1:0] wptr_ff;
	logic [PTR_W-1:0] rptr_ff;
	logic [CNT_W-1:0] count_ff;
	logic [ACC_W-1:0] acc_ff [2];
	logic [CNT_W-1:0] nmeas_ff [2];
	logic [1:0] inside_ff;
	logic [1:0] known_ff;
	logic [1:0] res_valid;
	logic [DATA_W-1:0] res_data [2];
	logic [1:0] enter;
	logic [1:0] leave;

	// Address decode
	logic sel_upper, sel_lower, sel_fifo, sel_irq_enable, sel_stat, sel_clr, sel_set;
	assign sel_upper = (i_addr == OFS_UPPER);
	assign sel_lower = (i_addr == OFS_LOWER);
	assign sel_fifo = (i_addr == OFS_FIFO);
	assign sel_irq_enable = (i_addr == OFS_IRQ_ENABLE);
	assign sel_stat = (i_addr == OFS_INTSTAT);
	assign sel_clr = (i_addr == OFS_INTCLR);
	assign sel_set = (i_addr == OFS_INTSET);

	// Per-slot configuration, averaging and window tracking
	for (genvar k = 0; k < 2; k++) begin : g_slot
		logic wr_cfg, hit, last, inside_now, cmp;
		logic [AVG_W-1:0] avg;
		logic [CNT_W-1:0] target;
		logic [SAMPLE_W-1:0] trunc_mask, meas_trunc;
		logic [ACC_W-1:0] sum;
		logic [SEL_W-1:0] sel;
		assign wr_cfg = i_wr & (i_addr == (k == 0 ? OFS_SLOT6 : OFS_SLOT7));
		assign avg = cfg_ff[k][AVG_LSB +: AVG_W];
		assign sel = cfg_ff[k][SEL_LSB +: SEL_W];
		// Only active slots take measurements
		assign hit = i_meas_valid & (i_meas_slot == SLOT_BASE + SLOT_W'(k))
			& cfg_ff[k][BIT_ACTIVE];
		// Drop two low bits per precision step
		assign trunc_mask = ~((SAMPLE_W'(1) << {cfg_ff[k][RES_LSB +: RES_W], 1'b0})
			- SAMPLE_W'(1));
		assign meas_trunc = i_meas_data & trunc_mask;
		assign target = CNT_W'(1) << avg;
		assign last = ((nmeas_ff[k] + CNT_W'(1)) == target);
		assign sum = acc_ff[k] + ACC_W'(meas_trunc);
		assign res_valid[k] = hit & last;
		assign res_data[k] = DATA_W'({sum, FRAC_W'(0)} >> avg);
		// Input classification for the analog front end
		assign o_slot_differential[k] = (sel == CH_DIFF0) | (sel == CH_DIFF0 + SEL_W'(1));
		assign o_slot_internal[k] = (sel >= CH_TEMP) & (sel <= CH_GND);
		assign o_slot_active[k] = cfg_ff[k][BIT_ACTIVE];
		assign o_slot_window_enable[k] = cfg_ff[k][BIT_WIN];
		// Window compare against both limits
		assign inside_now = (res_data[k] >= lower_ff) & (res_data[k] <= upper_ff);
		assign cmp = res_valid[k] & cfg_ff[k][BIT_WIN];
		assign enter[k] = cmp & known_ff[k] & inside_now & ~inside_ff[k];
		assign leave[k] = cmp & known_ff[k] & ~inside_now & inside_ff[k];
		// Configuration register, writable bits only
		always_ff @(posedge i_sys_clk or posedge i_rst) begin
			if (i_rst) begin
				cfg_ff[k] <= RST_VAL;
			end else if (wr_cfg) begin
				cfg_ff[k] <= i_wdata & CFG_WMASK;
			end
		end
		// Accumulator restarts on each configuration write
		always_ff @(posedge i_sys_clk or posedge i_rst) begin
			if (i_rst) begin
				acc_ff[k] <= '0;
				nmeas_ff[k] <= '0;
			end else if (wr_cfg || (hit && last)) begin
				acc_ff[k] <= '0;
				nmeas_ff[k] <= '0;
			end else if (hit) begin
				acc_ff[k] <= sum;
				nmeas_ff[k] <= nmeas_ff[k] + CNT_W'(1);
			end
		end
		// Last window side; first compare after enabling only records it
		always_ff @(posedge i_sys_clk or posedge i_rst) begin
			if (i_rst) begin
				inside_ff[k] <= 1'b0;
				known_ff[k] <= 1'b0;
			end else if (!cfg_ff[k][BIT_WIN]) begin
				known_ff[k] <= 1'b0;
			end else if (cmp) begin
				inside_ff[k] <= inside_now;
				known_ff[k] <= 1'b1;
			end
		end
	end

	assign o_slot6_average_count = cfg_ff[0][AVG_LSB +: AVG_W];
	assign o_slot7_average_count = cfg_ff[1][AVG_LSB +: AVG_W];
	assign o_slot6_resolution = cfg_ff[0][RES_LSB +: RES_W];
	assign o_slot7_resolution = cfg_ff[1][RES_LSB +: RES_W];
	assign o_slot6_input_select = cfg_ff[0][SEL_LSB +: SEL_W];
	assign o_slot7_input_select = cfg_ff[1][SEL_LSB +: SEL_W];

	// Result selection: slots below 6 pass straight through
	logic direct, push_valid, push_ok, pop, q_empty;
	logic [SLOT_W-1:0] push_slot;
	logic [DATA_W-1:0] push_data;
	logic [CNT_W-1:0] nxt_count;
	assign direct = i_meas_valid & (i_meas_slot < SLOT_BASE);
	assign push_valid = direct | (|res_valid);
	assign push_slot = res_valid[0] ? SLOT_BASE :
		res_valid[1] ? SLOT_BASE + SLOT_W'(1) : i_meas_slot;
	assign push_data = res_valid[0] ? res_data[0] :
		res_valid[1] ? res_data[1] : {i_meas_data, FRAC_W'(0)};
	assign q_empty = (count_ff == '0);
	assign push_ok = push_valid & (count_ff != Q_FULL); // Full queue drops the result
	assign pop = i_wr & sel_fifo & ~q_empty;
	assign nxt_count = count_ff + CNT_W'(push_ok) - CNT_W'(pop);

	// Queue storage and pointers
	always_ff @(posedge i_sys_clk) begin
		if (push_ok) begin
			mem[wptr_ff] <= {push_slot, push_data};
		end
	end
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			count_ff <= '0;
		end else begin
			wptr_ff <= wptr_ff + PTR_W'(push_ok);
			rptr_ff <= rptr_ff + PTR_W'(pop);
			count_ff <= nxt_count;
		end
	end

	// Events from conversions, scan completion, queue fill and window moves
	logic [INT_W-1:0] ev, clr_mask, set_mask, nxt_stat;
	assign ev[EV_SAMPLE] = push_valid;
	assign ev[EV_SWEEP] = i_scan_done;
	assign ev[EV_Q75] = (count_ff < Q_75) & (nxt_count >= Q_75);
	assign ev[EV_FULL] = (count_ff < Q_FULL) & (nxt_count == Q_FULL);
	assign ev[EV_EXIT] = |leave;
	assign ev[EV_ENTRY] = |enter;
	assign clr_mask = ((i_rd & sel_stat) ? '1 : '0)
		| ((i_wr & sel_clr) ? i_wdata[INT_W-1:0] : '0);
	assign set_mask = (i_wr & sel_set) ? i_wdata[INT_W-1:0] : '0;
	assign nxt_stat = (stat_ff & ~clr_mask) | ev | set_mask; // Set wins over clear
	assign o_irq = |(stat_ff & irq_enable_ff);

	// Limits, enable and status registers
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			upper_ff <= '0;
			lower_ff <= '0;
			irq_enable_ff <= '0;
			stat_ff <= '0;
		end else begin
			if (i_wr && sel_upper) upper_ff <= i_wdata[LIM_W-1:0];
			if (i_wr && sel_lower) lower_ff <= i_wdata[LIM_W-1:0];
			if (i_wr && sel_irq_enable) irq_enable_ff <= i_wdata[INT_W-1:0];
			stat_ff <= nxt_stat;
		end
	end

	// Read multiplexer, unused and reserved bits read zero
	logic [SLOT_W+DATA_W-1:0] head;
	logic [31:0] q_word, rd_mux;
	assign head = q_empty ? '0 : mem[rptr_ff];
	assign q_word = {1'b0, head[DATA_W +: SLOT_W], count_ff, head[DATA_W-1:0]};
	assign rd_mux = (i_addr == OFS_SLOT6) ? cfg_ff[0] :
		(i_addr == OFS_SLOT7) ? cfg_ff[1] :
		sel_upper ? {12'h000, upper_ff} :
		sel_lower ? {12'h000, lower_ff} :
		sel_fifo ? q_word :
		sel_irq_enable ? {26'h000_0000, irq_enable_ff} :
		sel_stat ? {26'h000_0000, stat_ff} : RST_VAL;
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= RST_VAL;
		end else begin
			rdata_ff <= i_rd ? rd_mux : RST_VAL;
		end
	end
	assign o_rdata = rdata_ff;

	// Checks on the block's own behaviour
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	property p_avg_one;
		(i_meas_valid && i_meas_slot == SLOT_BASE && cfg_ff[0][BIT_ACTIVE]
			&& cfg_ff[0][AVG_LSB +: AVG_W] == '0) |-> res_valid[0];
	endproperty
	a_avg_one: assert property (p_avg_one) else $error("single average not immediate");
	property p_res8;
		// Averaging shifts the zeroed low bits down by the averaging code
		(res_valid[0] && cfg_ff[0][RES_LSB +: RES_W] == 2'h3)
			|-> ((res_data[0] & ~({DATA_W{1'b1}}
			<< (DATA_W - 8 - int'(cfg_ff[0][AVG_LSB +: AVG_W])))) == '0);
	endproperty
	a_res8: assert property (p_res8) else $error("8-bit result has low bits");
	property p_skip;
		(i_meas_valid && i_meas_slot >= SLOT_BASE && !o_slot_active[i_meas_slot[0]])
			|-> !push_valid;
	endproperty
	a_skip: assert property (p_skip) else $error("disabled slot produced result");
	property p_win_off;
		(!cfg_ff[0][BIT_WIN] && !cfg_ff[1][BIT_WIN]) |-> (enter == '0 && leave == '0);
	endproperty
	a_win_off: assert property (p_win_off) else $error("window event while off");
	property p_upper;
		(i_wr && sel_upper) |=> (upper_ff == $past(i_wdata[LIM_W-1:0]));
	endproperty
	a_upper: assert property (p_upper) else $error("upper limit not stored");
	property p_lower;
		(i_rd && sel_lower) |=> (o_rdata == {12'h000, $past(lower_ff)});
	endproperty
	a_lower: assert property (p_lower) else $error("lower limit read wrong");
	property p_head;
		(i_rd && sel_fifo && !q_empty) |=> (o_rdata[DATA_W-1:0] == $past(head[DATA_W-1:0]));
	endproperty
	a_head: assert property (p_head) else $error("queue read not oldest");
	property p_count;
		(i_rd && sel_fifo) |=> (o_rdata[CNT_LSB +: CNT_W] == $past(count_ff));
	endproperty
	a_count: assert property (p_count) else $error("count field wrong");
	property p_pop;
		(i_wr && sel_fifo && !q_empty && !push_valid) |=> (count_ff == $past(count_ff) - 8'h01);
	endproperty
	a_pop: assert property (p_pop) else $error("pop did not decrement");
	property p_pop_empty;
		(i_wr && sel_fifo && q_empty && !push_valid) |=> q_empty;
	endproperty
	a_pop_empty: assert property (p_pop_empty) else $error("pop on empty changed count");
	property p_irq_gate;
		(irq_enable_ff == '0) |-> !o_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt while all masked");
	property p_full;
		(push_ok && count_ff == Q_FULL - 8'h01 && !pop) |=> stat_ff[EV_FULL];
	endproperty
	a_full: assert property (p_full) else $error("full event missing");
	property p_entry;
		(|enter) |=> stat_ff[EV_ENTRY];
	endproperty
	a_entry: assert property (p_entry) else $error("entry event missing");
	property p_sample;
		push_valid |=> stat_ff[EV_SAMPLE];
	endproperty
	a_sample: assert property (p_sample) else $error("conversion event missing");
	property p_clr;
		(i_wr && sel_clr) |=> ((stat_ff & $past(i_wdata[INT_W-1:0] & ~ev)) == '0);
	endproperty
	a_clr: assert property (p_clr) else $error("clear did not clear");
	property p_set;
		(i_wr && sel_set && i_wdata[EV_EXIT]) |=> stat_ff[EV_EXIT];
	endproperty
	a_set: assert property (p_set) else $error("set did not set");
	property p_rsvd;
		(i_rd && i_addr == OFS_SLOT6) |=> ((o_rdata & ~CFG_WMASK) == '0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

	// Further checks on fields, queue and events
	property p_avg_hold;
		(i_meas_valid && i_meas_slot == SLOT_BASE && cfg_ff[0][BIT_ACTIVE]
			&& cfg_ff[0][AVG_LSB +: AVG_W] != '0 && nmeas_ff[0] == '0) |-> !res_valid[0];
	endproperty
	a_avg_hold: assert property (p_avg_hold) else $error("average ended early");
	property p_res14;
		(res_valid[0] && cfg_ff[0][RES_LSB +: RES_W] == 2'h0 && cfg_ff[0][AVG_LSB +: AVG_W] == '0)
			|-> (res_data[0] == {i_meas_data, FRAC_W'(0)});
	endproperty
	a_res14: assert property (p_res14) else $error("full precision result altered");
	property p_pad;
		(o_slot6_input_select < CH_DIFF0) |-> (!o_slot_differential[0] && !o_slot_internal[0]);
	endproperty
	a_pad: assert property (p_pad) else $error("pad input misclassified");
	property p_gnd;
		(o_slot7_input_select == CH_GND) |-> o_slot_internal[1];
	endproperty
	a_gnd: assert property (p_gnd) else $error("ground not internal");
	property p_lim_rsvd;
		(i_rd && (sel_upper || sel_lower)) |=> (o_rdata[31:LIM_W] == '0);
	endproperty
	a_lim_rsvd: assert property (p_lim_rsvd) else $error("limit reserved bits set");
	property p_count_range;
		count_ff <= Q_FULL;
	endproperty
	a_count_range: assert property (p_count_range) else $error("count above depth");
	property p_pop_ptr;
		pop |=> (rptr_ff == $past(rptr_ff) + PTR_W'(1));
	endproperty
	a_pop_ptr: assert property (p_pop_ptr) else $error("pop did not advance head");
	property p_irq_full;
		(stat_ff[EV_FULL] && irq_enable_ff[EV_FULL]) |-> o_irq;
	endproperty
	a_irq_full: assert property (p_irq_full) else $error("enabled event no interrupt");
	property p_q75;
		(push_ok && count_ff == Q_75 - 8'h01 && !pop) |=> stat_ff[EV_Q75];
	endproperty
	a_q75: assert property (p_q75) else $error("three-quarter event missing");
	property p_exit;
		(|leave) |=> stat_ff[EV_EXIT];
	endproperty
	a_exit: assert property (p_exit) else $error("exit event missing");
	property p_sweep;
		i_scan_done |=> stat_ff[EV_SWEEP];
	endproperty
	a_sweep: assert property (p_sweep) else $error("scan event missing");
	property p_entry_move;
		(res_valid[0] && cfg_ff[0][BIT_WIN] && known_ff[0] && !inside_ff[0]
			&& res_data[0] >= lower_ff && res_data[0] <= upper_ff) |-> enter[0];
	endproperty
	a_entry_move: assert property (p_entry_move) else $error("no entry event");
	property p_exit_move;
		(res_valid[0] && cfg_ff[0][BIT_WIN] && known_ff[0] && inside_ff[0]
			&& res_data[0] > upper_ff) |-> leave[0];
	endproperty
	a_exit_move: assert property (p_exit_move) else $error("no exit event");

	c_pop: cover property (pop ##1 i_rd && sel_fifo);
	c_full: cover property (ev[EV_FULL]);
	c_q75: cover property (ev[EV_Q75]);
	c_entry_exit: cover property (|enter ##[1:200] |leave);
	c_irq: cover property (o_irq ##1 (i_rd && sel_stat) ##1 !o_irq);
endmodule : asq_slot_window_fifo
`default_nettype wire

/* File: test_adc_slot_window_fifo_regs.sv */
// Self-checking bench for the slot, window and result queue register block
`default_nettype none
module test_adc_slot_window_fifo_regs
	import asq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int DEPTH = 16;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [31:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_meas_valid = 1'b0;
	logic [SLOT_W-1:0] i_meas_slot = '0;
	logic [SAMPLE_W-1:0] i_meas_data = '0;
	logic i_scan_done = 1'b0;
	logic [31:0] o_rdata;
	logic [1:0] o_slot_active, o_slot_window_enable, o_slot_differential, o_slot_internal;
	logic [AVG_W-1:0] o_slot6_average_count, o_slot7_average_count;
	logic [RES_W-1:0] o_slot6_resolution, o_slot7_resolution;
	logic [SEL_W-1:0] o_slot6_input_select, o_slot7_input_select;
	logic o_irq;
	int fail_count = 0;
	int cmp_count = 0;

	asq_slot_window_fifo #(.FIFO_DEPTH(DEPTH)) uut (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_meas_valid(i_meas_valid),
		.i_meas_slot(i_meas_slot), .i_meas_data(i_meas_data), .i_scan_done(i_scan_done),
		.o_slot_active(o_slot_active), .o_slot_window_enable(o_slot_window_enable),
		.o_slot6_average_count(o_slot6_average_count),
		.o_slot7_average_count(o_slot7_average_count),
		.o_slot6_resolution(o_slot6_resolution), .o_slot7_resolution(o_slot7_resolution),
		.o_slot6_input_select(o_slot6_input_select),
		.o_slot7_input_select(o_slot7_input_select),
		.o_slot_differential(o_slot_differential), .o_slot_internal(o_slot_internal),
		.o_irq(o_irq)
	);

	// 20 MHz system clock
	always #25 i_sys_clk = ~i_sys_clk;

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One-cycle write strobe
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		#1;
	endtask : wr

	// One-cycle read strobe, data taken in the following cycle
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rdchk

	// One raw measurement pulse
	task automatic meas(input logic [SLOT_W-1:0] s, input logic [SAMPLE_W-1:0] d);
		@(posedge i_sys_clk);
		i_meas_valid <= 1'b1;
		i_meas_slot <= s;
		i_meas_data <= d;
		@(posedge i_sys_clk);
		i_meas_valid <= 1'b0;
		#1;
	endtask : meas

	// Verdict and end of run
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	// Main sequence
	initial begin
		logic [ADDR_W-1:0] regs [7];
		regs = '{OFS_SLOT6, OFS_SLOT7, OFS_UPPER, OFS_LOWER, OFS_FIFO, OFS_IRQ_ENABLE, OFS_INTSTAT};
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		foreach (regs[k]) rdchk(regs[k], RST_VAL);
		rdchk(10'h100, 32'h0000_0000);
		// Field storage, reserved bits and decoded outputs
		wr(OFS_SLOT6, 32'hFFFF_FFFF);
		rdchk(OFS_SLOT6, 32'h0703_0F03);
		chk(32'({o_slot6_average_count, o_slot6_resolution, o_slot6_input_select}),
			32'h1FF);
		chk(32'({o_slot_active[0], o_slot_window_enable[0]}), 32'h3);
		wr(OFS_SLOT7, 32'h0502_0A02);
		rdchk(OFS_SLOT7, 32'h0502_0A02);
		chk(32'({o_slot7_average_count, o_slot7_resolution, o_slot7_input_select}),
			32'h16A);
		chk(32'({o_slot_active[1], o_slot_window_enable[1]}), 32'h1);
		// Every input code on both slots, including the unused top code
		for (int c = 0; c < 16; c++) begin
			wr(OFS_SLOT6, 32'(c) << SEL_LSB);
			wr(OFS_SLOT7, 32'(c) << SEL_LSB);
			chk(32'({o_slot_differential, o_slot_internal}),
				32'({{2{c == 10 || c == 11}}, {2{c >= 12 && c <= 14}}}));
		end
		wr(OFS_UPPER, 32'hFFFF_FFFF);
		rdchk(OFS_UPPER, 32'h000F_FFFF);
		wr(OFS_LOWER, 32'hFFF5_A5A5);
		rdchk(OFS_LOWER, 32'h0005_A5A5);
		// Every averaging code: first sample doubled so a wrong count shows
		for (int n = 0; n < 8; n++) begin
			wr(OFS_SLOT6, 32'h1 | (32'(n) << AVG_LSB));
			meas(3'h6, 14'h0200);
			repeat ((1 << n) - 1) meas(3'h6, 14'h0100);
			rdchk(OFS_FIFO, {4'h6, 8'h01, 20'h04000 + (20'h04000 >> n)});
			wr(OFS_FIFO, 32'h0);
		end
		// Every precision code; each step above code 0 truncates two more low bits
		for (int r = 0; r < 4; r++) begin
			wr(OFS_SLOT6, 32'h1 | (32'(r) << RES_LSB));
			meas(3'h6, 14'h3FFF);
			rdchk(OFS_FIFO, {4'h6, 8'h01, ((20'h03FFF >> (2 * r)) << (2 * r)) << 6});
			wr(OFS_FIFO, 32'h0);
		end
		wr(OFS_SLOT7, 32'h0);
		meas(3'h7, 14'h0123);
		rdchk(OFS_FIFO, 32'h0);
		// Queue order, slot number, count and pop on empty
		meas(3'h2, 14'h1234);
		meas(3'h5, 14'h3FFF);
		rdchk(OFS_FIFO, 32'h2024_8D00);
		wr(OFS_FIFO, 32'h0);
		rdchk(OFS_FIFO, 32'h501F_FFC0);
		wr(OFS_FIFO, 32'h0);
		wr(OFS_FIFO, 32'hFFFF_FFFF);
		rdchk(OFS_FIFO, 32'h0);
		// Fill levels raise the 75% and full events
		wr(OFS_IRQ_ENABLE, 32'h08);
		rdchk(OFS_INTSTAT, 32'h01);
		for (int k = 0; k < 12; k++) meas(3'h0, 14'(k));
		rdchk(OFS_INTSTAT, 32'h05);
		for (int k = 12; k < DEPTH + 1; k++) meas(3'h0, 14'(k));
		chk({31'h0, o_irq}, 32'h1);
		rdchk(OFS_INTSTAT, 32'h09);
		chk({31'h0, o_irq}, 32'h0);
		rdchk(OFS_FIFO, {4'h0, 8'(DEPTH), 20'h0});
		repeat (DEPTH + 1) wr(OFS_FIFO, 32'h0);
		rdchk(OFS_FIFO, 32'h0);
		// Window entry at the lower boundary and exit above the upper limit
		wr(OFS_LOWER, 32'h400);
		wr(OFS_UPPER, 32'h1000);
		wr(OFS_SLOT6, 32'h3);
		meas(3'h6, 14'h0000);
		rdchk(OFS_INTSTAT, 32'h01);
		meas(3'h6, 14'h0010);
		rdchk(OFS_INTSTAT, 32'h21);
		meas(3'h6, 14'h0041);
		rdchk(OFS_INTSTAT, 32'h11);
		meas(3'h6, 14'h0040);
		rdchk(OFS_INTSTAT, 32'h21);
		wr(OFS_SLOT6, 32'h1);
		meas(3'h6, 14'h0000);
		rdchk(OFS_INTSTAT, 32'h01);
		repeat (DEPTH) wr(OFS_FIFO, 32'h0);
		// Set, clear, mask and scan events
		wr(OFS_IRQ_ENABLE, 32'hFFFF_FFFF);
		rdchk(OFS_IRQ_ENABLE, 32'h3F);
		wr(OFS_IRQ_ENABLE, 32'h0);
		wr(OFS_INTSET, 32'hFFFF_FFFF);
		chk({31'h0, o_irq}, 32'h0);
		rdchk(OFS_INTSTAT, 32'h3F);
		wr(OFS_IRQ_ENABLE, 32'h04);
		wr(OFS_INTSET, 32'h07);
		chk({31'h0, o_irq}, 32'h1);
		wr(OFS_INTCLR, 32'h05);
		chk({31'h0, o_irq}, 32'h0);
		rdchk(OFS_INTSTAT, 32'h02);
		@(posedge i_sys_clk);
		i_scan_done <= 1'b1;
		@(posedge i_sys_clk);
		i_scan_done <= 1'b0;
		rdchk(OFS_INTSTAT, 32'h02);
		// Reset in mid-run returns registers to zero
		wr(OFS_SLOT7, 32'h0107_0301);
		@(posedge i_sys_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rdchk(OFS_SLOT7, RST_VAL);
		end_sim();
	end

	// Watchdog against a hung sequence
	initial begin
		#(20000 * 50);
		fail_count++;
		$display("[ERR] %0t ns: watchdog expired", $time);
		end_sim();
	end
endmodule : test_adc_slot_window_fifo_regs
`default_nettype wire
